/* File: sim/dpj_operator.sv */
// Purpose: operator panel buttons and configuration tool link
// Assumes: caller is just past a rising edge of aclk
// Notes: button codes 0 mode, 1 up, 2 down, 3 set, 4 tool link
module dpj_operator (
    input wire logic aclk,
    output logic btn_mode,
    output logic btn_up,
    output logic btn_down,
    output logic btn_set,
    output logic tool_link_ok,
    output logic emergency_stop_input
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        btn_mode = 1'b0;
        btn_up = 1'b0;
        btn_down = 1'b0;
        btn_set = 1'b0;
        tool_link_ok = 1'b1;
        emergency_stop_input = 1'b1;
    end
    task automatic hold(input int w, input logic v);
        case (w)
            0: btn_mode <= v;
            1: btn_up <= v;
            2: btn_down <= v;
            3: btn_set <= v;
            default: tool_link_ok <= v;
        endcase
    endtask
    // idle gap after release lets the debouncer settle before the next press
    task automatic press(input int w, input int cyc);
        hold(w, 1'b1);
        repeat (cyc) @(posedge aclk);
        hold(w, 1'b0);
        repeat (8) @(posedge aclk);
    endtask
endmodule // dpj_operator

/* File: sim/dpj_panel_chk.sv */
// Purpose: port-level assertions for the panel control block
// Assumes: one clock, every non-AXI output registered once
// Notes: bound into each dpj_panel instance
module dpj_panel_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic alarm_valid,
    input wire logic alarm_reset_input,
    input wire logic servo_on_input,
    input wire logic pulse_clear_input,
    input wire logic forward_start_input,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic emergency_stop_input,
    input wire logic ext_cmd_active,
    input wire logic tool_link_ok,
    input wire logic [4:0] core_outputs,
    input wire logic [4:0] do_pins,
    input wire logic [3:0] disp_screen,
    input wire logic [5:0] seg_upper,
    input wire logic [4:0] seg_lower,
    input wire logic alarm_clear,
    input wire logic jog_run,
    input wire logic jog_ccw,
    input wire logic jog_decel_stop,
    input wire logic [15:0] jog_speed,
    input wire logic [15:0] jog_tc_ms
);
    timeunit 1ns;
    timeprecision 100ps;
    import dpj_pkg::*;
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_jog_defaults: assert property ($rose(aresetn) |-> jog_speed == 16'h00C8 && jog_tc_ms == 16'h03E8)
        else $error("jog defaults wrong after reset");
    chk_tc_limit: assert property (jog_tc_ms <= 16'hC350)
        else $error("jog time constant above limit");
    chk_upper_inputs: assert property ($past(aresetn) |-> seg_upper == $past({emergency_stop_input,
        reverse_limit_input, forward_limit_input, pulse_clear_input, servo_on_input, forward_start_input}))
        else $error("upper segments do not follow inputs");
    chk_lower_outputs: assert property ($past(aresetn) |-> seg_lower == $past(do_pins))
        else $error("lower segments do not follow outputs");
    chk_force_blocked: assert property (servo_on_input [*3] |-> do_pins == $past(core_outputs))
        else $error("outputs forced while servo on");
    chk_ext_blocks_jog: assert property (ext_cmd_active [*3] |-> !jog_run)
        else $error("jog runs under external command");
    chk_link_loss_decel: assert property ($fell(tool_link_ok) && jog_run ##1 !jog_run |-> jog_decel_stop)
        else $error("no decel stop after link loss");
    chk_alarm_screen: assert property ($rose(alarm_valid) |-> ##[1:4] disp_screen == DPJ_SCR_ALARM)
        else $error("alarm screen not shown");
    chk_reset_clears: assert property ($past(alarm_valid) && $rose(alarm_reset_input) |-> ##[1:4] alarm_clear)
        else $error("alarm reset input ignored");
    chk_clear_pulse: assert property (alarm_clear |=> !alarm_clear)
        else $error("alarm clear longer than one cycle");
    cov_clear: cover property ($rose(alarm_clear));
    cov_jog_ccw: cover property (jog_run && jog_ccw);
    cov_decel: cover property ($rose(jog_decel_stop));
endmodule // dpj_panel_chk

bind dpj_panel dpj_panel_chk i_chk (
    .aclk, .aresetn, .alarm_valid, .alarm_reset_input, .servo_on_input, .pulse_clear_input,
    .forward_start_input, .forward_limit_input, .reverse_limit_input, .emergency_stop_input,
    .ext_cmd_active, .tool_link_ok, .core_outputs, .do_pins, .disp_screen, .seg_upper, .seg_lower,
    .alarm_clear, .jog_run, .jog_ccw, .jog_decel_stop, .jog_speed, .jog_tc_ms
);

/* File: sim/testbench.sv */
// Purpose: self-checking bench of the panel control block
// Assumes: short hold, debounce and blink counts
// Notes: registers reached over AXI4-Lite tasks
`include "dpj_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dpj_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, alarm_valid, param_fault_alarm;
    logic [7:0] s_axi_awaddr, s_axi_araddr, alarm_code, param_fault_num;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, disp_screen;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic btn_mode, btn_up, btn_down, btn_set, alarm_reset_input, servo_on_input, pulse_clear_input;
    logic forward_start_input, forward_limit_input, reverse_limit_input, emergency_stop_input;
    logic ext_cmd_active, tool_link_ok, alarm_clear, jog_run, jog_ccw, jog_decel_stop, exp_access;
    logic [4:0] core_outputs, do_pins, seg_lower;
    logic [8:0] disp_code;
    logic [5:0] seg_upper;
    logic [15:0] jog_speed, jog_tc_ms;
    logic [2:0] seen;
    int errors, comparisons, cycles, n_clr;
    dpj_panel #(.HOLD_CYC(20), .DEB_CYC(2), .BLINK_CYC(4)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .btn_mode, .btn_up, .btn_down, .btn_set, .alarm_valid, .alarm_code, .param_fault_alarm,
        .param_fault_num, .alarm_reset_input, .servo_on_input, .pulse_clear_input, .forward_start_input,
        .forward_limit_input, .reverse_limit_input, .emergency_stop_input, .ext_cmd_active, .tool_link_ok,
        .core_outputs, .do_pins, .disp_code, .disp_screen, .seg_upper, .seg_lower, .alarm_clear, .jog_run,
        .jog_ccw, .jog_decel_stop, .jog_speed, .jog_tc_ms, .exp_access
    );
    dpj_operator i_op (
        .aclk, .btn_mode, .btn_up, .btn_down, .btn_set, .tool_link_ok, .emergency_stop_input
    );
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        if (alarm_clear === 1'b1)
            n_clr++;
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end
    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic goto(input logic [3:0] t);
        for (int i = 0; i < 10 && disp_screen !== t; i++)
            i_op.press(0, 8);
        check(disp_screen, t);
    endtask
    task automatic alarm(input logic [7:0] c);
        alarm_code <= c;
        alarm_valid <= 1'b1;
        repeat (5) @(posedge aclk);
        check(disp_screen, DPJ_SCR_ALARM);
    endtask
    // 24 samples span three blink periods
    task automatic watch(input logic [7:0] c);
        seen = 3'b000;
        repeat (24)
        begin
            @(posedge aclk);
            if (disp_code[7:0] === c)
                seen[0] = 1'b1;
            if (disp_code[7:0] === 8'hFF)
                seen[1] = 1'b1;
            if (disp_code[8] === 1'b1)
                seen[2] = 1'b1;
        end
    endtask
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alarm_valid, alarm_code} = '0;
        {param_fault_alarm, param_fault_num, alarm_reset_input, servo_on_input, ext_cmd_active} = '0;
        {pulse_clear_input, forward_start_input, forward_limit_input, reverse_limit_input} = 4'hA;
        s_axi_wstrb = 4'hF;
        core_outputs = 5'h00;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`DPJ_OFS_JOG_SPEED, d);
        check(d, 32'h000000C8);
        rd(`DPJ_OFS_JOG_TC, d);
        check(d, 32'h000003E8);
        wr(`DPJ_OFS_JOG_TC, 32'h0000EA60);
        rd(`DPJ_OFS_JOG_TC, d);
        check(d, 32'h0000C350);
        rd(8'h3C, d);
        check(d, 32'h00000000);
        rd(`DPJ_OFS_HIST, d);
        check(d, 32'h00000000);
        check(exp_access, 1'b0);
        wr(`DPJ_OFS_CTRL, 32'h00000002);
        repeat (2) @(posedge aclk);
        check(exp_access, 1'b1);
        alarm(8'h33);
        watch(8'h33);
        check(seen[1:0], 2'b11);
        i_op.press(0, 8);
        watch(8'h33);
        check(seen[2], 1'b1);
        {alarm_valid, alarm_reset_input} <= 2'b01;
        repeat (4) @(posedge aclk);
        alarm_reset_input <= 1'b0;
        repeat (2) @(posedge aclk);
        check(n_clr, 1);
        alarm(8'h50);
        alarm_valid <= 1'b0;
        i_op.press(3, 8);
        check(n_clr, 2);
        rd(`DPJ_OFS_HIST, d);
        check(d, 32'h00000050);
        goto(DPJ_SCR_HIST);
        i_op.press(2, 8);
        rd(`DPJ_OFS_HIST_SEL, d);
        check(d, 32'h00000001);
        rd(`DPJ_OFS_HIST, d);
        check(d, 32'h00000033);
        i_op.press(1, 8);
        rd(`DPJ_OFS_HIST_SEL, d);
        check(d, 32'h00000000);
        i_op.press(3, 40);
        check(disp_screen, DPJ_SCR_MAINT);
        wr(`DPJ_OFS_CTRL, 32'h00000001);
        rd(`DPJ_OFS_HIST, d);
        check(d, 32'h00000000);
        wr(`DPJ_OFS_CTRL, 32'h00000004);
        wr(`DPJ_OFS_FORCE, 32'h00000015);
        core_outputs <= 5'h0A;
        repeat (3) @(posedge aclk);
        check(do_pins, 5'h15);
        servo_on_input <= 1'b1;
        repeat (4) @(posedge aclk);
        check(do_pins, 5'h0A);
        servo_on_input <= 1'b0;
        {param_fault_alarm, param_fault_num} <= 9'h101;
        repeat (3) @(posedge aclk);
        rd(`DPJ_OFS_PARAM, d);
        check(d, 32'h00000101);
        param_fault_alarm <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(`DPJ_OFS_PARAM, d);
        check(d[8], 1'b0);
        goto(DPJ_SCR_DIAG);
        servo_on_input <= 1'b1;
        i_op.press(3, 8);
        check(disp_screen, DPJ_SCR_DIAG);
        servo_on_input <= 1'b0;
        i_op.press(3, 8);
        check(disp_screen, DPJ_SCR_JOG);
        for (int b = 1; b < 3; b++)
        begin
            i_op.hold(b, 1'b1);
            repeat (8) @(posedge aclk);
            check({jog_run, jog_ccw, disp_screen}, {1'b1, b == 1, DPJ_SCR_JOG});
            i_op.hold(b, 1'b0);
            repeat (8) @(posedge aclk);
            check(jog_run, 1'b0);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(`DPJ_OFS_CTRL, i ? 32'h00000028 : 32'h00000018);
            repeat (4) @(posedge aclk);
            check({jog_run, jog_ccw}, i ? 2'b10 : 2'b11);
        end
        ext_cmd_active <= 1'b1;
        repeat (4) @(posedge aclk);
        check(jog_run, 1'b0);
        ext_cmd_active <= 1'b0;
        repeat (4) @(posedge aclk);
        i_op.hold(4, 1'b0);
        repeat (4) @(posedge aclk);
        check(jog_decel_stop, 1'b1);
        i_op.hold(4, 1'b1);
        wr(`DPJ_OFS_CTRL, 32'h00000000);
        for (int i = 0; i < 5; i++)
        begin
            i_op.press(0, 8);
            check(disp_screen, i < 4 ? DPJ_SCR_STATUS : DPJ_SCR_JOG);
        end
        i_op.press(3, 40);
        check(disp_screen, DPJ_SCR_DIAG);
        results();
    end
endmodule // testbench

/* File: src/dpj_panel.sv */
// Purpose: front-panel alarm display, alarm history, DO forcing and jog control
// Assumes: buttons and pins synchronous to aclk; AXI4-Lite master keeps one access at a time
// Notes: display code bits [7:0] are the two low digits, bit 8 the fourth-digit decimal point
`include "dpj_regs.svh"

module dpj_panel #(
    parameter int HOLD_CYC = `DPJ_HOLD_CYC,
    parameter int DEB_CYC = `DPJ_DEB_CYC,
    parameter int BLINK_CYC = `DPJ_BLINK_CYC,
    parameter int NUM_STATUS = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic btn_mode,
    input wire logic btn_up,
    input wire logic btn_down,
    input wire logic btn_set,
    input wire logic alarm_valid,
    input wire logic [7:0] alarm_code,
    input wire logic param_fault_alarm,
    input wire logic [7:0] param_fault_num,
    input wire logic alarm_reset_input,
    input wire logic servo_on_input,
    input wire logic pulse_clear_input,
    input wire logic forward_start_input,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic emergency_stop_input,
    input wire logic ext_cmd_active,
    input wire logic tool_link_ok,
    input wire logic [4:0] core_outputs,
    output logic [4:0] do_pins,
    output logic [8:0] disp_code,
    output logic [3:0] disp_screen,
    output logic [5:0] seg_upper,
    output logic [4:0] seg_lower,
    output logic alarm_clear,
    output logic jog_run,
    output logic jog_ccw,
    output logic jog_decel_stop,
    output logic [15:0] jog_speed,
    output logic [15:0] jog_tc_ms,
    output logic exp_access
);
    import dpj_pkg::*;

    logic [3:0] btn_raw;
    logic [3:0] btn_deb_r;
    logic [3:0] btn_prev_r;
    logic [3:0] btn_press;
    logic set_long_r;
    logic [31:0] hold_cnt_r;
    logic [31:0] blink_cnt_r;
    logic blink_r;
    logic alarm_act_r;
    dpj_code_t alarm_r;
    dpj_code_t hist_r [`DPJ_HIST_DEPTH];
    logic [2:0] hist_sel_r;
    dpj_screen_e scr_r;
    dpj_test_e tm_r;
    logic [2:0] stat_idx_r;
    logic [31:0] ctrl_r;
    logic [15:0] speed_r;
    logic [15:0] tc_r;
    logic [4:0] force_r;
    logic aw_r;
    logic w_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic alarm_new;
    logic clr_req;

    assign btn_raw = {btn_set, btn_down, btn_up, btn_mode};
    assign btn_press = btn_deb_r & ~btn_prev_r;
    assign alarm_new = alarm_valid && !alarm_act_r;
    assign clr_req = (btn_press[3] && scr_r == DPJ_SCR_ALARM) || alarm_reset_input;
    assign wr_go = aw_r && w_r && !s_axi_bvalid;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_deb
            logic [31:0] cnt_r;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    cnt_r <= '0;
                    btn_deb_r[gi] <= 1'b0;
                end
                else if (btn_raw[gi] == btn_deb_r[gi])
                    cnt_r <= '0;
                else if (cnt_r >= 32'(DEB_CYC - 1))
                begin
                    cnt_r <= '0;
                    btn_deb_r[gi] <= btn_raw[gi];
                end
                else
                    cnt_r <= cnt_r + 32'd1;
            end
        end
    endgenerate

    // long press fires once per hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            btn_prev_r <= '0;
            hold_cnt_r <= '0;
            set_long_r <= 1'b0;
        end
        else
        begin
            btn_prev_r <= btn_deb_r;
            set_long_r <= 1'b0;
            if (!btn_deb_r[3])
                hold_cnt_r <= '0;
            else if (hold_cnt_r < 32'(HOLD_CYC))
            begin
                hold_cnt_r <= hold_cnt_r + 32'd1;
                set_long_r <= (hold_cnt_r == 32'(HOLD_CYC - 1));
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end
        else if (blink_cnt_r >= 32'(BLINK_CYC - 1))
        begin
            blink_cnt_r <= '0;
            blink_r <= ~blink_r;
        end
        else
            blink_cnt_r <= blink_cnt_r + 32'd1;
    end

    // alarm latch; a new alarm the same cycle as a clear wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_act_r <= 1'b0;
            alarm_r <= `DPJ_NO_ALARM;
        end
        else if (alarm_new)
        begin
            alarm_act_r <= 1'b1;
            alarm_r <= alarm_code;
        end
        else if (clr_req)
        begin
            alarm_act_r <= 1'b0;
            alarm_r <= `DPJ_NO_ALARM;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < `DPJ_HIST_DEPTH; i++)
                hist_r[i] <= `DPJ_NO_ALARM;
        end
        else if (alarm_new)
        begin
            hist_r[0] <= alarm_code;
            for (int i = 1; i < `DPJ_HIST_DEPTH; i++)
                hist_r[i] <= hist_r[i-1];
        end
        else if (wr_go && awaddr_r == `DPJ_OFS_CTRL && wdata_r[`DPJ_CTRL_HIST_CLR])
        begin
            for (int i = 0; i < `DPJ_HIST_DEPTH; i++)
                hist_r[i] <= `DPJ_NO_ALARM;
        end
    end

    // screen navigation and test mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scr_r <= DPJ_SCR_STATUS;
            tm_r <= DPJ_TM_IDLE;
            stat_idx_r <= '0;
            hist_sel_r <= '0;
        end
        else if (alarm_new && tm_r == DPJ_TM_IDLE)
            scr_r <= DPJ_SCR_ALARM;
        else
        begin
            case (tm_r)
                DPJ_TM_IDLE:
                begin
                    if (btn_press[0])
                        scr_r <= (scr_r >= DPJ_SCR_PARAM) ? DPJ_SCR_STATUS : dpj_screen_e'(scr_r + 4'd1);
                    else if (scr_r == DPJ_SCR_HIST && btn_press[1] && hist_sel_r != 3'd0)
                        hist_sel_r <= hist_sel_r - 3'd1;
                    else if (scr_r == DPJ_SCR_HIST && btn_press[2] && hist_sel_r != 3'(`DPJ_HIST_DEPTH - 1))
                        hist_sel_r <= hist_sel_r + 3'd1;
                    else if (scr_r == DPJ_SCR_HIST && set_long_r)
                        scr_r <= DPJ_SCR_MAINT;
                    else if (scr_r == DPJ_SCR_DIAG && btn_press[3] && !servo_on_input && !ext_cmd_active)
                    begin
                        tm_r <= DPJ_TM_READY;
                        scr_r <= DPJ_SCR_JOG;
                    end
                end
                DPJ_TM_READY, DPJ_TM_STATUS:
                begin
                    if (btn_press[0])
                    begin
                        if (tm_r == DPJ_TM_READY)
                        begin
                            tm_r <= DPJ_TM_STATUS;
                            stat_idx_r <= '0;
                        end
                        else if (stat_idx_r == 3'(NUM_STATUS - 1))
                            tm_r <= DPJ_TM_EXIT;
                        else
                            stat_idx_r <= stat_idx_r + 3'd1;
                    end
                end
                DPJ_TM_EXIT:
                begin
                    if (set_long_r)
                    begin
                        tm_r <= DPJ_TM_IDLE;
                        scr_r <= DPJ_SCR_DIAG;
                    end
                    else if (btn_press[0])
                        tm_r <= DPJ_TM_READY;
                end
                default:
                    tm_r <= DPJ_TM_IDLE;
            endcase
        end
    end

    // AXI4-Lite write side; address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_r && !s_axi_bvalid;
    assign s_axi_wready = !w_r && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;

    // strobes only gate these registers: an all-zero strobe leaves them unchanged, any other takes the register as a whole word; the history clear ignores strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= '0;
            speed_r <= `DPJ_JOG_SPEED_RST;
            tc_r <= `DPJ_JOG_TC_RST;
            force_r <= '0;
        end
        else if (wr_go && wstrb_r != 4'h0)
        begin
            case (awaddr_r)
                `DPJ_OFS_CTRL: ctrl_r <= {26'h0, wdata_r[5:1], 1'b0};
                `DPJ_OFS_JOG_SPEED: speed_r <= wdata_r[15:0];
                `DPJ_OFS_JOG_TC: tc_r <= (wdata_r[15:0] > `DPJ_JOG_TC_MAX) ? `DPJ_JOG_TC_MAX : wdata_r[15:0];
                `DPJ_OFS_FORCE: force_r <= wdata_r[4:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read side
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `DPJ_OFS_CTRL: s_axi_rdata <= ctrl_r;
                `DPJ_OFS_STATUS: s_axi_rdata <= {24'h0, tm_r, scr_r, servo_on_input, alarm_act_r};
                `DPJ_OFS_ALARM: s_axi_rdata <= {24'h0, alarm_r};
                `DPJ_OFS_HIST: s_axi_rdata <= {24'h0, hist_r[hist_sel_r]};
                `DPJ_OFS_PARAM: s_axi_rdata <= {23'h0, param_fault_alarm, param_fault_num};
                `DPJ_OFS_JOG_SPEED: s_axi_rdata <= {16'h0, speed_r};
                `DPJ_OFS_JOG_TC: s_axi_rdata <= {16'h0, tc_r};
                `DPJ_OFS_FORCE: s_axi_rdata <= {27'h0, force_r};
                `DPJ_OFS_DISPLAY: s_axi_rdata <= {23'h0, disp_code};
                `DPJ_OFS_HIST_SEL: s_axi_rdata <= {29'h0, hist_sel_r};
                default: s_axi_rdata <= '0;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    // display and pin outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disp_code <= '0;
            disp_screen <= '0;
            seg_upper <= '0;
            seg_lower <= '0;
            do_pins <= '0;
            alarm_clear <= 1'b0;
            exp_access <= 1'b0;
        end
        else
        begin
            disp_screen <= (tm_r == DPJ_TM_STATUS) ? 4'(DPJ_SCR_STATUS) : scr_r;
            case (scr_r)
                DPJ_SCR_ALARM: disp_code[7:0] <= (alarm_act_r && blink_r) ? 8'hFF : alarm_r;
                DPJ_SCR_HIST, DPJ_SCR_MAINT: disp_code[7:0] <= hist_r[hist_sel_r];
                DPJ_SCR_PARERR: disp_code[7:0] <= param_fault_alarm ? param_fault_num : `DPJ_NO_ALARM;
                DPJ_SCR_JOG: disp_code[7:0] <= {5'h0, stat_idx_r};
                default: disp_code[7:0] <= 8'h00;
            endcase
            disp_code[8] <= alarm_act_r && blink_r;
            seg_upper <= {emergency_stop_input, reverse_limit_input, forward_limit_input,
                pulse_clear_input, servo_on_input, forward_start_input};
            seg_lower <= do_pins;
            do_pins <= (ctrl_r[`DPJ_CTRL_FORCE_EN] && !servo_on_input) ? force_r : core_outputs;
            alarm_clear <= clr_req && alarm_act_r && !alarm_new;
            exp_access <= ctrl_r[`DPJ_CTRL_EXP_EN];
        end
    end

    // jog drive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            jog_run <= 1'b0;
            jog_ccw <= 1'b0;
            jog_decel_stop <= 1'b0;
            jog_speed <= `DPJ_JOG_SPEED_RST;
            jog_tc_ms <= `DPJ_JOG_TC_RST;
        end
        else
        begin
            jog_speed <= speed_r;
            jog_tc_ms <= tc_r;
            jog_decel_stop <= ctrl_r[`DPJ_CTRL_TOOL_JOG] && !tool_link_ok;
            if (tm_r == DPJ_TM_IDLE || ext_cmd_active || !emergency_stop_input)
            begin
                jog_run <= 1'b0;
                jog_ccw <= 1'b0;
            end
            else if (ctrl_r[`DPJ_CTRL_TOOL_JOG])
            begin
                jog_run <= tool_link_ok && (ctrl_r[`DPJ_CTRL_TOOL_UP] ^ ctrl_r[`DPJ_CTRL_TOOL_DN]);
                jog_ccw <= ctrl_r[`DPJ_CTRL_TOOL_UP];
            end
            else
            begin
                jog_run <= btn_deb_r[1] ^ btn_deb_r[2];
                jog_ccw <= btn_deb_r[1];
            end
        end
    end

endmodule // dpj_panel

/* File: src/dpj_pkg.sv */
// Purpose: types of the panel control block
// Assumes: nothing beyond the register header
// Notes: screens and test-mode states
package dpj_pkg;
    typedef enum logic [3:0] {
        DPJ_SCR_STATUS, DPJ_SCR_DIAG, DPJ_SCR_ALARM, DPJ_SCR_HIST, DPJ_SCR_PARERR,
        DPJ_SCR_PARAM, DPJ_SCR_MAINT, DPJ_SCR_JOG
    } dpj_screen_e;
    typedef enum logic [1:0] {DPJ_TM_IDLE, DPJ_TM_READY, DPJ_TM_STATUS, DPJ_TM_EXIT} dpj_test_e;
    typedef logic [7:0] dpj_code_t;
endpackage

/* File: src/dpj_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts of the panel control block
// Assumes: 200 MHz aclk, AXI4-Lite word registers
// Notes: all constants as macros; types live in dpj_pkg
`ifndef DPJ_REGS_SVH
`define DPJ_REGS_SVH
`define DPJ_CLK_MHZ 200
`define DPJ_OFS_CTRL 8'h00
`define DPJ_OFS_STATUS 8'h04
`define DPJ_OFS_ALARM 8'h08
`define DPJ_OFS_HIST 8'h0C
`define DPJ_OFS_PARAM 8'h10
`define DPJ_OFS_JOG_SPEED 8'h14
`define DPJ_OFS_JOG_TC 8'h18
`define DPJ_OFS_FORCE 8'h1C
`define DPJ_OFS_DISPLAY 8'h20
`define DPJ_OFS_HIST_SEL 8'h24
`define DPJ_CTRL_HIST_CLR 0
`define DPJ_CTRL_EXP_EN 1
`define DPJ_CTRL_FORCE_EN 2
`define DPJ_CTRL_TOOL_JOG 3
`define DPJ_CTRL_TOOL_UP 4
`define DPJ_CTRL_TOOL_DN 5
`define DPJ_JOG_SPEED_RST 16'h00C8
`define DPJ_JOG_TC_RST 16'h03E8
`define DPJ_JOG_TC_MAX 16'hC350
`define DPJ_NO_ALARM 8'h00
`define DPJ_HOLD_MS 2000
`define DPJ_HOLD_CYC (`DPJ_HOLD_MS * 1000 * `DPJ_CLK_MHZ)
`define DPJ_DEB_US 10
`define DPJ_DEB_CYC (`DPJ_DEB_US * `DPJ_CLK_MHZ)
`define DPJ_BLINK_MS 250
`define DPJ_BLINK_CYC (`DPJ_BLINK_MS * 1000 * `DPJ_CLK_MHZ)
`define DPJ_HIST_DEPTH 6
`define DPJ_NUM_SCREENS 8
`endif
